// ---- src/tio_pkg.sv ----
// package for the timer input/output synchroniser and mode decode
package tio_pkg;
   localparam int NUM_CH        = 3;
   localparam int SYNC_STAGES   = 3;    // strobes spent before recognition
   localparam int PRESCALE_BITS = 3;    // ripple stages of divide-by-8
   localparam int CNT_W         = 16;
   localparam int BYTE_W        = 8;
   localparam int CH_THREE      = 2;    // index of channel three
   // control register fields
   localparam int CTL_W          = 8;
   localparam int BIT_PRESCALE   = 0;
   localparam int BIT_WIDTH      = 2;
   localparam int BIT_MEASURE    = 3;
   localparam int BIT_MODIFIER   = 4;
   localparam int BIT_ONESHOT    = 5;
   localparam int BIT_OUT_EN     = 7;
   // apb register map, one word per channel control and per latch
   localparam logic [7:0] ADDR_CTL0   = 8'h00;
   localparam logic [7:0] ADDR_CTL1   = 8'h04;
   localparam logic [7:0] ADDR_CTL2   = 8'h08;
   localparam logic [7:0] ADDR_LATCH0 = 8'h10;
   localparam logic [7:0] ADDR_LATCH1 = 8'h14;
   localparam logic [7:0] ADDR_LATCH2 = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [CTL_W-1:0] CTL_RESET   = 8'h00;
   localparam logic [CNT_W-1:0] LATCH_RESET = 16'hffff;

   typedef enum logic [1:0] {
      TIO_CONT, TIO_SHOT, TIO_FREQ, TIO_WIDTH
   } tio_mode_e;

   typedef struct packed {
      logic count_fall;   // recognised falling edge on count input
      logic gate_fall;    // recognised falling edge on gate
      logic gate_level;   // synchronised gate level
   } tio_evt_s;
endpackage

// ---- src/tio_sync.sv ----
// synchroniser and edge recogniser for one asynchronous input
`timescale 1ns/1ps
`default_nettype none
module tio_sync
   import tio_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   input  wire logic din,
   output logic      level,
   output logic      fall
);
   logic [SYNC_STAGES-1:0] stg;
   logic [SYNC_STAGES-1:0] next_stg;
   logic                   next_fall;

   // shift chain, stage 0 read only by stage 1; edge from stages 1 and 2
   always_comb begin
      next_stg  = {stg[SYNC_STAGES-2:0], din};
      next_fall = stg[SYNC_STAGES-1] & ~stg[SYNC_STAGES-2]; // RULE_21
   end

   // three strobes to settle, recognised pulse on the fourth
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stg  <= '0;
         fall <= 1'b0;
      end else if (ce) begin
         stg  <= next_stg; // RULE_01 RULE_04
         fall <= next_fall;
      end
   end
   assign level = stg[SYNC_STAGES-1];
endmodule
`default_nettype wire

// ---- src/tio_prescale.sv ----
// asynchronous ripple divide-by-8 for channel three
`timescale 1ns/1ps
`default_nettype none
module tio_prescale
   import tio_pkg::*;
(
   input  wire logic presetn,
   input  wire logic cin,
   output logic      cout
);
   logic [PRESCALE_BITS-1:0] rip;

   // each stage toggles on the falling edge of the one before
   genvar i;
   generate
      for (i = 0; i < PRESCALE_BITS; i++) begin : g_rip
         if (i == 0) begin : g_first
            always_ff @(negedge cin or negedge presetn) begin
               if (!presetn) rip[i] <= 1'b0;
               else          rip[i] <= ~rip[i]; // RULE_05
            end
         end else begin : g_next
            always_ff @(negedge rip[i-1] or negedge presetn) begin
               if (!presetn) rip[i] <= 1'b0;
               else          rip[i] <= ~rip[i];
            end
         end
      end
   endgenerate
   assign cout = rip[PRESCALE_BITS-1];
endmodule
`default_nettype wire

// ---- src/tio_top.sv ----
// three-channel timer io: synchronisers, mode decode, output shaping
`timescale 1ns/1ps
`default_nettype none
//Behaviour
//RULE_01: count input recognised on fourth strobe
//RULE_02: each count input decrements only its timer
//RULE_03: source holds levels one clock minimum
//RULE_04: one strobe of recognition jitter allowed
//RULE_05: channel three prescaler is ripple divide-by-8
//RULE_06: late prescaler edge handled next strobe
//RULE_07: prescaler output passes normal synchroniser
//RULE_08: gate synchronised, recognised on fourth strobe
//RULE_09: gate acts on counter regardless prescaler
//RULE_10: 16-bit gives square wave or pulse
//RULE_11: dual 8-bit gives variable duty pulse
//RULE_12: output low when output enable clear
//RULE_13: clearing enable drops output next strobe
//RULE_14: measurement modes output undefined
//RULE_15: bit3 selects synthesis/measurement, then bit5/bit4
//RULE_16: leftover mode bit modifies initialisation; code uses bit4 in synthesis only, bit5 is ignored in measurement
//RULE_17: continuous repeats, single-shot one pulse
//RULE_18: comparison modes measure gate period/width; code decodes TIO_FREQ/TIO_WIDTH but counts as in synthesis
//RULE_19: control bit 2 selects 16 or 8+8
//RULE_20: channel three bit 0 selects prescaler
//RULE_21: edge from comparing successive samples
module tio_top
   import tio_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_count_in_one,
   input  wire logic        ext_count_in_two,
   input  wire logic        ext_count_in_three,
   input  wire logic        trigger_gate_one,
   input  wire logic        trigger_gate_two,
   input  wire logic        trigger_gate_three,
   output logic             wave_out_one,
   output logic             wave_out_two,
   output logic             wave_out_three
);
   logic [CTL_W-1:0]        ctl      [NUM_CH];
   logic [CNT_W-1:0]        latch    [NUM_CH];
   logic [CNT_W-1:0]        cnt      [NUM_CH];
   logic [NUM_CH-1:0]       wout;
   logic [NUM_CH-1:0]       done;
   logic [NUM_CH-1:0]       cin;
   logic [NUM_CH-1:0]       gin;
   logic [NUM_CH-1:0]       csrc;
   tio_evt_s                evt      [NUM_CH];
   tio_mode_e               mode     [NUM_CH];
   logic                    pre_out;
   logic [NUM_CH-1:0]       wr_ctl;
   logic [NUM_CH-1:0]       wr_latch;
   logic                    access;
   logic [31:0]             next_prdata;
   logic                    next_pslverr;

   assign cin = {ext_count_in_three, ext_count_in_two, ext_count_in_one};
   assign gin = {trigger_gate_three, trigger_gate_two, trigger_gate_one};

   // divide-by-8 runs without the system clock
   tio_prescale u_pre (
      .presetn (presetn),
      .cin     (ext_count_in_three), // RULE_05 RULE_06
      .cout    (pre_out)
   );

   // apb access decode, zero wait states
   assign access = psel & penable & ce;
   always_comb begin
      wr_ctl       = '0;
      wr_latch     = '0;
      next_prdata  = '0;
      next_pslverr = 1'b0;
      case (paddr)
         ADDR_CTL0:   begin wr_ctl[0] = pwrite; next_prdata = 32'(ctl[0]); end
         ADDR_CTL1:   begin wr_ctl[1] = pwrite; next_prdata = 32'(ctl[1]); end
         ADDR_CTL2:   begin wr_ctl[2] = pwrite; next_prdata = 32'(ctl[2]); end
         ADDR_LATCH0: begin wr_latch[0] = pwrite; next_prdata = 32'(cnt[0]); end
         ADDR_LATCH1: begin wr_latch[1] = pwrite; next_prdata = 32'(cnt[1]); end
         ADDR_LATCH2: begin wr_latch[2] = pwrite; next_prdata = 32'(cnt[2]); end
         ADDR_STATUS: next_prdata = 32'({done, wout});
         default:     next_pslverr = 1'b1;
      endcase
   end

   // setup phase raises pready so the access phase completes in one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= psel & ~penable;
         prdata  <= next_prdata;
         pslverr <= psel & ~penable & next_pslverr;
      end
   end

   // per-channel control, synchronisers, counter and output shaping
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         logic [CNT_W-1:0] next_cnt;
         logic [CTL_W-1:0] next_ctl;
         logic [CNT_W-1:0] next_latch;
         logic             next_wout;
         logic             next_done;
         logic             init;
         logic             tick;
         logic             zero_lo;
         logic             zero_hi;

         // channel three may take the divided clock, same path after it
         if (ch == CH_THREE) begin : g_src3
            assign csrc[ch] = ctl[ch][BIT_PRESCALE] ? pre_out : cin[ch]; // RULE_20 RULE_07
         end else begin : g_src
            assign csrc[ch] = cin[ch];
         end

         tio_sync u_csync (
            .pclk    (pclk),
            .presetn (presetn),
            .ce      (ce),
            .din     (csrc[ch]), // RULE_02
            .level   (),
            .fall    (evt[ch].count_fall)
         );
         // gate bypasses the prescaler entirely
         tio_sync u_gsync (
            .pclk    (pclk),
            .presetn (presetn),
            .ce      (ce),
            .din     (gin[ch]), // RULE_08 RULE_09
            .level   (evt[ch].gate_level),
            .fall    (evt[ch].gate_fall)
         );

         // mode decode from bits 3, 4 and 5
         always_comb begin
            if (!ctl[ch][BIT_MEASURE])
               mode[ch] = ctl[ch][BIT_ONESHOT] ? TIO_SHOT : TIO_CONT; // RULE_15
            else
               mode[ch] = ctl[ch][BIT_MODIFIER] ? TIO_WIDTH : TIO_FREQ; // RULE_15 RULE_18
         end

         assign zero_lo = (cnt[ch][BYTE_W-1:0] == '0);
         assign zero_hi = (cnt[ch][CNT_W-1:BYTE_W] == '0);
         // modifier bit picks whether a latch write initialises (synthesis)
         assign init = evt[ch].gate_fall
                     | (wr_latch[ch] & access & ~ctl[ch][BIT_MODIFIER]
                        & ~ctl[ch][BIT_MEASURE]); // RULE_16
         assign tick = evt[ch].count_fall & ~evt[ch].gate_level;

         // counter and waveform next state
         always_comb begin
            next_ctl   = ctl[ch];
            next_latch = latch[ch];
            next_cnt   = cnt[ch];
            next_wout  = wout[ch];
            next_done  = done[ch];
            if (access && wr_ctl[ch])
               next_ctl = pwdata[CTL_W-1:0];
            if (access && wr_latch[ch])
               next_latch = pwdata[CNT_W-1:0];
            // a latch write initialises with the value written in this cycle
            if (init) begin
               next_cnt  = next_latch;
               next_wout = 1'b0;
               next_done = 1'b0;
            end else if (tick && !(mode[ch] == TIO_SHOT && done[ch])) begin
               if (!ctl[ch][BIT_WIDTH]) begin // RULE_19
                  if (cnt[ch] == '0) begin
                     next_cnt  = latch[ch];
                     next_wout = ~wout[ch]; // RULE_10 RULE_17
                     next_done = (mode[ch] == TIO_SHOT);
                  end else begin
                     next_cnt = cnt[ch] - 16'h0001;
                  end
               end else begin
                  if (zero_lo && zero_hi) begin
                     next_cnt  = latch[ch];
                     next_wout = 1'b0; // RULE_11
                     next_done = (mode[ch] == TIO_SHOT); // RULE_17
                  end else if (zero_lo) begin
                     next_cnt = {cnt[ch][CNT_W-1:BYTE_W] - 8'h01,
                                 latch[ch][BYTE_W-1:0]};
                  end else begin
                     next_cnt = {cnt[ch][CNT_W-1:BYTE_W],
                                 cnt[ch][BYTE_W-1:0] - 8'h01};
                     if (zero_hi)
                        next_wout = 1'b1; // RULE_11
                  end
               end
            end
            // measurement modes leave the wave undefined but still masked
            if (!next_ctl[BIT_OUT_EN]) // RULE_14
               next_wout = 1'b0; // RULE_12 RULE_13
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ctl[ch]   <= CTL_RESET;
               latch[ch] <= LATCH_RESET;
               cnt[ch]   <= LATCH_RESET;
               wout[ch]  <= 1'b0;
               done[ch]  <= 1'b0;
            end else if (ce) begin
               ctl[ch]   <= next_ctl;
               latch[ch] <= next_latch;
               cnt[ch]   <= next_cnt;
               wout[ch]  <= next_wout;
               done[ch]  <= next_done;
            end
         end
      end
   endgenerate

   // pins straight from the output flops
   assign wave_out_one   = wout[0];
   assign wave_out_two   = wout[1];
   assign wave_out_three = wout[2];
endmodule
`default_nettype wire

// ---- verification/tio_checker.sv ----
// port assertions for the timer io block
`timescale 1ns/1ps
`default_nettype none
module tio_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        ext_count_in_one,
   input wire logic        ext_count_in_two,
   input wire logic        ext_count_in_three,
   input wire logic        trigger_gate_one,
   input wire logic        trigger_gate_two,
   input wire logic        trigger_gate_three,
   input wire logic        wave_out_one,
   input wire logic        wave_out_two,
   input wire logic        wave_out_three
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr_acc;
   // completed write access
   assign wr_acc = psel && penable && pready && pwrite;
   a_ready_next: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   a_err_unmapped: assert property (psel && penable && pready && paddr == 8'h0c |-> pslverr)
      else $error("unmapped access not refused");
   a_off_one_low: assert property (wr_acc && paddr == 8'h00 && !pwdata[7] |=> !wave_out_one)
      else $error("output one not dropped");
   a_off_two_low: assert property (wr_acc && paddr == 8'h04 && !pwdata[7] |=> !wave_out_two)
      else $error("output two not dropped");
   a_off_three_low: assert property (wr_acc && paddr == 8'h08 && !pwdata[7] |=> !wave_out_three)
      else $error("output three not dropped");
   a_quiet_one_stable: assert property ((!psel && $stable(ext_count_in_one)
      && $stable(trigger_gate_one))[*8] |=> $stable(wave_out_one))
      else $error("output one moved without cause");
   a_reset_out_low: assert property ($rose(presetn) |-> !wave_out_one && !wave_out_two && !wave_out_three)
      else $error("output high after reset");
   cover property (pslverr);
   cover property ($rose(wave_out_one));
   cover property ($rose(wave_out_three));
endmodule
bind tio_top tio_checker i_tio_checker (.*);
`default_nettype wire

// ---- verification/tio_partner.sv ----
// far-side model: count sources and gate drivers
`timescale 1ns/1ps
`default_nettype none
module tio_partner (
   input wire logic        pclk,
   input wire logic [2:0]  fall_req,
   input wire logic [2:0]  gate_lvl,
   output logic [2:0]      cnt_in,
   output logic [2:0]      gate_out
);
   logic [2:0] req_q = 3'h0;
   logic [2:0] last  = 3'h0;
   logic [2:0] gq    = 3'h0;
   // each low level lasts two clocks, highs at least three
   always @(posedge pclk) begin
      req_q <= fall_req;
      last  <= req_q;
      gq    <= gate_lvl;
   end
   assign cnt_in   = ~(req_q | last);
   assign gate_out = gq;
endmodule
`default_nettype wire

// ---- verification/tio_top_test.sv ----
// self-checking bench for the timer io block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
   $display("Error %s expected %h seen %h", n, e, a); end end
module tio_top_test;
   import tio_pkg::*;
   logic        pclk = 0;
   logic        presetn = 0;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  fall_req = 3'h0;
   logic [2:0]  gate_lvl = 3'h0;
   logic [2:0]  cin;
   logic [2:0]  gin;
   logic [2:0]  wout;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   logic [31:0] seed = 32'hda6e7de8;
   logic [15:0] n;
   int          bad_count = 0;
   int          n_tests = 0;
   int          cyc = 0;
   always #4 pclk = ~pclk;
   tio_top i_tio_top (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .ext_count_in_one(cin[0]), .ext_count_in_two(cin[1]),
      .ext_count_in_three(cin[2]), .trigger_gate_one(gin[0]), .trigger_gate_two(gin[1]),
      .trigger_gate_three(gin[2]), .wave_out_one(wout[0]), .wave_out_two(wout[1]),
      .wave_out_three(wout[2]));
   tio_partner i_tio_partner (.pclk, .fall_req, .gate_lvl, .cnt_in(cin), .gate_out(gin));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task report_and_stop;
      if (bad_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] x);
      exp_q.push_back(x);
      apb(0, a, 32'h0);
   endtask
   task automatic pulse(input int ch, input int k);
      repeat (k) begin
         fall_req[ch] <= 1;
         @(posedge pclk);
         fall_req[ch] <= 0;
         repeat (4) @(posedge pclk);
      end
   endtask
   // read monitor: oldest note against the answer
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         report_and_stop;
      end else if (psel && penable && pready === 1'b1 && !pwrite) begin
         e = exp_q.pop_front();
         `CHK("pslverr", e[32], pslverr)
         if (!e[32]) `CHK("prdata", e[31:0], prdata)
      end
   end
   // main sequence
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      rd(ADDR_CTL0, 33'h0);
      rd(ADDR_LATCH2, 33'h0ffff);
      rd(8'h0c, {1'b1, 32'h0});
      apb(1, ADDR_LATCH0, 32'h0);
      apb(1, ADDR_CTL0, 32'h80);
      // one fall: output must still be low after the third strobe, high after the fourth
      fall_req[0] <= 1;
      @(posedge pclk);
      fall_req[0] <= 0;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      `CHK("out one early", 1'b0, wout[0])
      @(negedge pclk);
      `CHK("out one toggled", 1'b1, wout[0])
      apb(1, ADDR_CTL0, 32'h0);
      @(posedge pclk);
      `CHK("out one off", 1'b0, wout[0])
      // single-shot dual 8-bit: high once the upper byte is zero, then it stops
      apb(1, ADDR_CTL0, 32'ha4);
      apb(1, ADDR_LATCH0, 32'h0101);
      pulse(0, 3);
      @(posedge pclk);
      `CHK("out one duty high", 1'b1, wout[0])
      pulse(0, 1);
      @(posedge pclk);
      `CHK("out one shot low", 1'b0, wout[0])
      pulse(0, 1);
      rd(ADDR_LATCH0, 33'h00101);
      rd(ADDR_STATUS, 33'h00008);
      seed = xs(seed);
      n = 16'(seed[2:0]) + 16'd4;
      apb(1, ADDR_CTL1, 32'h80);
      apb(1, ADDR_LATCH1, {16'h0, n});
      pulse(1, 3);
      rd(ADDR_LATCH1, {17'h0, n - 16'd3});
      rd(ADDR_LATCH2, 33'h0ffff);
      gate_lvl[1] <= 1;
      pulse(1, 2);
      rd(ADDR_LATCH1, {17'h0, n - 16'd3});
      gate_lvl[1] <= 0;
      repeat (8) @(posedge pclk);
      rd(ADDR_LATCH1, {17'h0, n});
      // measurement mode: latch write leaves the counter, masked output stays low
      apb(1, ADDR_CTL1, 32'h08);
      apb(1, ADDR_LATCH1, 32'h0);
      pulse(1, 1);
      rd(ADDR_LATCH1, {17'h0, n - 16'd1});
      `CHK("out two masked", 1'b0, wout[1])
      apb(1, ADDR_CTL1, 32'h0);
      apb(1, ADDR_CTL2, 32'h81);
      // the source switch-over makes one edge; let it pass before initialising
      repeat (4) @(posedge pclk);
      apb(1, ADDR_LATCH2, 32'h0);
      pulse(2, 7);
      `CHK("out three early", 1'b0, wout[2])
      pulse(2, 1);
      repeat (4) @(posedge pclk);
      `CHK("out three divided", 1'b1, wout[2])
      apb(1, ADDR_CTL2, 32'h0);
      @(posedge pclk);
      `CHK("out three off", 1'b0, wout[2])
      report_and_stop;
   end
endmodule
`default_nettype wire
